// >>> design/mts_pkg.sv
package mts_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] MTS_OFF_TRIG_SEL = 8'h00;
  localparam logic [7:0] MTS_OFF_CMD_VAL  = 8'h04;
  localparam logic [7:0] MTS_OFF_CMD      = 8'h08;
  localparam logic [7:0] MTS_OFF_STATUS   = 8'h0c;
  localparam logic [7:0] MTS_OFF_ABS_POS  = 8'h10;
  localparam logic [7:0] MTS_OFF_ENC_POS  = 8'h14;
  localparam logic [7:0] MTS_OFF_SPEED    = 8'h18;
  localparam logic [7:0] MTS_OFF_HOME_SRC = 8'h1c;
  localparam logic [7:0] MTS_OFF_PROG     = 8'h20;

  // ****************************************
  // Field positions and values
  // ****************************************
  localparam int         MTS_STAT_BUSY_BIT = 0;
  localparam int         MTS_STAT_WAIT_BIT = 1;
  localparam int         MTS_STAT_ERR_LSB  = 8;
  localparam int         MTS_PROG_START_BIT = 0;
  localparam logic [2:0] MTS_TRIG_NONE     = 3'h0;
  localparam logic [2:0] MTS_TRIG_EV1      = 3'h1;
  localparam logic [2:0] MTS_TRIG_EV2      = 3'h2;
  localparam logic [2:0] MTS_TRIG_MAX      = 3'h4;
  localparam logic [1:0] MTS_HSRC_EV1      = 2'h0;
  localparam logic [1:0] MTS_HSRC_EV2      = 2'h1;
  localparam logic [1:0] MTS_HSRC_MARK     = 2'h2;
  localparam logic [7:0] MTS_ERR_NONE      = 8'h00;
  localparam logic [7:0] MTS_ERR_RANGE     = 8'h15;
  localparam logic [32:0] MTS_MAX_COUNTS   = 33'h0_7fff_ffff;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] MTS_RST_SPEED    = 32'h0000_0000;
  localparam logic [1:0]  MTS_RST_HOME_SRC = 2'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    MTS_CMD_ABS,
    MTS_CMD_INC,
    MTS_CMD_HOME
  } mts_cmd_t;

  typedef enum logic [1:0] {
    MTS_MODE_HOLD,
    MTS_MODE_POS,
    MTS_MODE_VEL,
    MTS_MODE_STOP
  } mts_mode_t;

  typedef enum {
    MTS_ST_IDLE,
    MTS_ST_ARM,
    MTS_ST_POS_RUN,
    MTS_ST_HOME_RUN,
    MTS_ST_HOME_STOP
  } mts_state_t;

  // Command to the profile generator
  typedef struct packed {
    mts_mode_t          mode;
    logic               neg_dir;
    logic signed [31:0] target;
    logic [31:0]        speed;
  } mts_prof_cmd_t;

  // Synchronised field inputs
  typedef struct packed {
    logic ev1;
    logic ev2;
    logic marker;
    logic enc_step;
    logic enc_dir;
  } mts_field_t;

endpackage

// >>> design/mts_sync.sv
`timescale 1ns/1ps
module mts_sync
  import mts_pkg::*;
#(
  parameter int W = 5
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // Two stage synchroniser; the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// >>> design/mts_pos_counter.sv
`timescale 1ns/1ps
module mts_pos_counter
  import mts_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                step,
  input  wire logic                neg_dir,
  input  wire logic                load,
  input  wire logic signed [W-1:0] load_val,
  output logic signed      [W-1:0] count_q
);

  // Load wins over a step in the same cycle; only the homing reload has the step in load_val, the clear load does not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= load_val;
    end else if (step) begin
      count_q <= neg_dir ? count_q - W'(1) : count_q + W'(1);
    end
  end

endmodule

// >>> design/mts_sequencer.sv
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// R1 - Trigger select 0 none, 1 waits first event, 2 waits second event.
// R2 - Written trigger select above 4 becomes 0.
// R3 - Program start resets trigger select to no trigger.
// R4 - Triggered motion starts within 1 ms of the event going active.
// R5 - Trigger select writes ignored while commanded motion is in progress.
// R6 - Selected trigger gates every motion kind, only event inputs as sources.
// R7 - Trigger select reads back the active selection.
// R8 - Absolute move drives motor to target measured from home zero.
// R9 - Absolute target too far from position sets error 21, no motion.
// R10 - Incremental move travels signed distance from present position.
// R11 - Incremental magnitude above 2147483647 sets error 21, no motion.
// R12 - Homing uses only the sign of its value for direction.
// R13 - Homing runs at the last written speed.
// R14 - Homing trigger selectable: first event, second event or marker.
// R15 - Homing trigger already active clears both counters, no motion.
// R16 - Otherwise accelerate to speed and hold until homing trigger.
// R17 - On homing trigger decelerate to a stop.
// R18 - After stop counters load distance travelled since trigger.
// R19 - Busy reads 1 once motion has actually started.
// R20 - Positions and targets are signed 32-bit encoder counts.
module mts_sequencer
  import mts_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          first_event_input,
  input  wire logic          second_event_input,
  input  wire logic          enc_marker,
  input  wire logic          enc_step,
  input  wire logic          enc_dir,
  input  wire logic          prof_done,
  output mts_prof_cmd_t      prof_cmd,
  output logic               prof_go,
  output logic               motion_busy
);

  // ****************************************
  // Field input synchronisers
  // ****************************************
  mts_field_t f_raw;
  mts_field_t f_s;
  logic       step_d1_q;
  logic       step_pulse;

  assign f_raw = '{ev1: first_event_input, ev2: second_event_input,
                   marker: enc_marker, enc_step: enc_step, enc_dir: enc_dir};

  mts_sync #(.W($bits(mts_field_t))) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (f_raw),
    .sync_out (f_s)
  );

  // Step edge detector works on the second stage only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_d1_q <= 1'b0;
    end else begin
      step_d1_q <= f_s.enc_step;
    end
  end
  assign step_pulse = f_s.enc_step & ~step_d1_q;

  // ****************************************
  // APB slave
  // ****************************************
  logic        access;
  logic        wr_en;
  logic        mapped;
  logic [31:0] rdata_d;

  assign access = psel & penable;
  // A write lands on the edge where pready is seen high
  assign wr_en  = access & pwrite & pready;

  always_comb begin
    unique case (paddr)
      MTS_OFF_TRIG_SEL, MTS_OFF_CMD_VAL, MTS_OFF_CMD, MTS_OFF_STATUS,
      MTS_OFF_ABS_POS, MTS_OFF_ENC_POS, MTS_OFF_SPEED, MTS_OFF_HOME_SRC,
      MTS_OFF_PROG: mapped = 1'b1;
      default:      mapped = 1'b0;
    endcase
  end

  // One wait state so that read data comes straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      prdata  <= (access & ~pready & ~pwrite) ? rdata_d : '0;
    end
  end

  // ****************************************
  // Software visible settings
  // ****************************************
  mts_state_t         state_q;
  logic [2:0]         trig_sel_q;
  logic signed [31:0] cmd_val_q;
  logic [1:0]         cmd_q;
  logic [31:0]        speed_q;
  logic [1:0]         home_src_q;
  logic [7:0]         err_q;
  logic               prog_start;
  logic               idle;

  assign idle       = (state_q == MTS_ST_IDLE);
  assign prog_start = wr_en & (paddr == MTS_OFF_PROG) & pwdata[MTS_PROG_START_BIT];

  // Trigger select register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_sel_q <= MTS_TRIG_NONE;
    // R3 program start default
    end else if (prog_start) begin
      trig_sel_q <= MTS_TRIG_NONE;
    // R5 ignored while moving
    end else if (wr_en && paddr == MTS_OFF_TRIG_SEL && idle) begin
      // R2 out of range forced
      if (pwdata > 32'(MTS_TRIG_MAX)) begin
        trig_sel_q <= MTS_TRIG_NONE;
      end else begin
        trig_sel_q <= pwdata[2:0];
      end
    end
  end

  // Command value, speed and homing source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_val_q  <= '0;
      speed_q    <= MTS_RST_SPEED;
      home_src_q <= MTS_RST_HOME_SRC;
    end else if (wr_en) begin
      if (paddr == MTS_OFF_CMD_VAL) begin
        cmd_val_q <= pwdata;
      end
      // R13 latest speed setting
      if (paddr == MTS_OFF_SPEED) begin
        speed_q <= pwdata;
      end
      // R14 homing source select
      if (paddr == MTS_OFF_HOME_SRC) begin
        home_src_q <= pwdata[1:0];
      end
    end
  end

  // ****************************************
  // Position counters
  // ****************************************
  logic signed [31:0] abs_pos;
  logic signed [31:0] enc_pos;
  logic signed [31:0] abs_cap_q;
  logic signed [31:0] enc_cap_q;
  logic               pos_load;
  logic signed [31:0] abs_load_val;
  logic signed [31:0] enc_load_val;

  // R20 signed 32-bit counts
  mts_pos_counter #(.W(32)) u_abs (
    .pclk     (pclk),
    .presetn  (presetn),
    .step     (step_pulse),
    .neg_dir  (f_s.enc_dir),
    .load     (pos_load),
    .load_val (abs_load_val),
    .count_q  (abs_pos)
  );

  mts_pos_counter #(.W(32)) u_enc (
    .pclk     (pclk),
    .presetn  (presetn),
    .step     (step_pulse),
    .neg_dir  (f_s.enc_dir),
    .load     (pos_load),
    .load_val (enc_load_val),
    .count_q  (enc_pos)
  );

  // ****************************************
  // Command decode and range checks
  // ****************************************
  logic               cmd_wr;
  logic signed [32:0] abs_dist;
  logic               range_bad;
  logic               start_ok;
  logic               home_trig;
  logic               start_trig;

  assign cmd_wr = wr_en & (paddr == MTS_OFF_CMD);

  // R9 distance to absolute target
  assign abs_dist = 33'(cmd_val_q) - 33'(abs_pos);

  function automatic logic too_far(input logic signed [32:0] d);
    too_far = (d > $signed(MTS_MAX_COUNTS)) || (d < -$signed(MTS_MAX_COUNTS));
  endfunction

  always_comb begin
    unique case (pwdata[1:0])
      MTS_CMD_ABS: range_bad = too_far(abs_dist);
      // R11 incremental magnitude
      MTS_CMD_INC: range_bad = too_far(33'(cmd_val_q));
      default:     range_bad = 1'b0;
    endcase
  end

  assign start_ok = cmd_wr & idle & (pwdata[1:0] != 2'h3) & ~range_bad;

  // R14 homing trigger source
  always_comb begin
    unique case (home_src_q)
      MTS_HSRC_EV1:  home_trig = f_s.ev1;
      MTS_HSRC_EV2:  home_trig = f_s.ev2;
      MTS_HSRC_MARK: home_trig = f_s.marker;
      default:       home_trig = 1'b0;
    endcase
  end

  // R1 select start trigger
  // R6 only event inputs gate
  always_comb begin
    unique case (trig_sel_q)
      MTS_TRIG_EV1: start_trig = f_s.ev1;
      MTS_TRIG_EV2: start_trig = f_s.ev2;
      default:      start_trig = 1'b1;
    endcase
  end

  // Error code, set wins over a clearing write to status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= MTS_ERR_NONE;
    // R9 R11 range error
    end else if (cmd_wr && idle && range_bad) begin
      err_q <= MTS_ERR_RANGE;
    end else if (wr_en && paddr == MTS_OFF_STATUS) begin
      err_q <= MTS_ERR_NONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= 2'h0;
    end else if (start_ok) begin
      cmd_q <= pwdata[1:0];
    end
  end

  // ****************************************
  // Motion state machine
  // ****************************************
  logic go_now;

  // R4 starts one cycle after trigger seen
  assign go_now = (state_q == MTS_ST_ARM) & start_trig;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= MTS_ST_IDLE;
    end else begin
      unique case (state_q)
        MTS_ST_IDLE: begin
          if (start_ok) begin
            state_q <= MTS_ST_ARM;
          end
        end
        MTS_ST_ARM: begin
          if (go_now) begin
            if (cmd_q != MTS_CMD_HOME) begin
              state_q <= MTS_ST_POS_RUN;
            // R15 already triggered, no motion
            end else if (home_trig) begin
              state_q <= MTS_ST_IDLE;
            end else begin
              state_q <= MTS_ST_HOME_RUN;
            end
          end
        end
        MTS_ST_POS_RUN: begin
          if (prof_done) begin
            state_q <= MTS_ST_IDLE;
          end
        end
        // R17 decelerate on trigger
        MTS_ST_HOME_RUN: begin
          if (home_trig) begin
            state_q <= MTS_ST_HOME_STOP;
          end
        end
        MTS_ST_HOME_STOP: begin
          if (prof_done) begin
            state_q <= MTS_ST_IDLE;
          end
        end
      endcase
    end
  end

  // Trigger position capture for homing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abs_cap_q <= '0;
      enc_cap_q <= '0;
    end else if (state_q == MTS_ST_HOME_RUN && home_trig) begin
      abs_cap_q <= abs_pos;
      enc_cap_q <= enc_pos;
    end
  end

  // R15 clear on immediate trigger
  // R18 reload with travel since trigger
  assign pos_load = (go_now & (cmd_q == MTS_CMD_HOME) & home_trig) |
                    ((state_q == MTS_ST_HOME_STOP) & prof_done);
  assign abs_load_val = (state_q == MTS_ST_HOME_STOP) ?
                        abs_pos - abs_cap_q + (step_pulse ? (f_s.enc_dir ? -32'sd1 : 32'sd1) : 32'sd0) :
                        '0;
  assign enc_load_val = (state_q == MTS_ST_HOME_STOP) ?
                        enc_pos - enc_cap_q + (step_pulse ? (f_s.enc_dir ? -32'sd1 : 32'sd1) : 32'sd0) :
                        '0;

  // ****************************************
  // Profile generator command
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prof_cmd <= '{mode: MTS_MODE_HOLD, neg_dir: 1'b0, target: '0, speed: '0};
      prof_go  <= 1'b0;
    end else begin
      prof_go <= 1'b0;
      if (go_now && !(cmd_q == MTS_CMD_HOME && home_trig)) begin
        prof_go        <= 1'b1;
        prof_cmd.speed <= speed_q;
        unique case (cmd_q)
          // R8 absolute target from zero
          MTS_CMD_ABS: begin
            prof_cmd.mode    <= MTS_MODE_POS;
            prof_cmd.target  <= cmd_val_q;
            prof_cmd.neg_dir <= cmd_val_q < abs_pos;
          end
          // R10 signed distance from here
          MTS_CMD_INC: begin
            prof_cmd.mode    <= MTS_MODE_POS;
            prof_cmd.target  <= abs_pos + cmd_val_q;
            prof_cmd.neg_dir <= cmd_val_q[31];
          end
          // R12 sign only; R16 run at speed
          default: begin
            prof_cmd.mode    <= MTS_MODE_VEL;
            prof_cmd.target  <= '0;
            prof_cmd.neg_dir <= cmd_val_q[31];
          end
        endcase
      end else if (state_q == MTS_ST_HOME_RUN && home_trig) begin
        // R17 stop at deceleration rate
        prof_go       <= 1'b1;
        prof_cmd.mode <= MTS_MODE_STOP;
      end
    end
  end

  // R19 busy once motion started
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      motion_busy <= 1'b0;
    end else begin
      motion_busy <= (go_now & ~(cmd_q == MTS_CMD_HOME & home_trig)) |
                     (motion_busy & ~(prof_done & (state_q == MTS_ST_POS_RUN ||
                                                   state_q == MTS_ST_HOME_STOP)));
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    rdata_d = '0;
    unique case (paddr)
      // R7 reads active selection
      MTS_OFF_TRIG_SEL: rdata_d = {29'h0, trig_sel_q};
      MTS_OFF_CMD_VAL:  rdata_d = cmd_val_q;
      MTS_OFF_CMD:      rdata_d = {30'h0, cmd_q};
      MTS_OFF_STATUS: begin
        rdata_d[MTS_STAT_BUSY_BIT] = motion_busy;
        rdata_d[MTS_STAT_WAIT_BIT] = (state_q == MTS_ST_ARM);
        rdata_d[MTS_STAT_ERR_LSB +: 8] = err_q;
      end
      MTS_OFF_ABS_POS:  rdata_d = abs_pos;
      MTS_OFF_ENC_POS:  rdata_d = enc_pos;
      MTS_OFF_SPEED:    rdata_d = speed_q;
      MTS_OFF_HOME_SRC: rdata_d = {30'h0, home_src_q};
      default:          rdata_d = '0;
    endcase
  end

endmodule

// >>> sim/mts_sequencer_sva.sv
`timescale 1ns/1ps
// ****************************************
// Port checker for the sequencer
// ****************************************
module mts_sequencer_chk
  import mts_pkg::*;
(
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          first_event_input,
  input wire logic          second_event_input,
  input wire logic          enc_marker,
  input wire logic          enc_step,
  input wire logic          enc_dir,
  input wire logic          prof_done,
  input wire mts_prof_cmd_t prof_cmd,
  input wire logic          prof_go,
  input wire logic          motion_busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // One wait state, answer stands one cycle
  a_apb_wait: assert property ((psel && penable && !$past(penable)) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_unmapped: assert property ((pready && paddr > 8'h20) |-> pslverr)
    else $error("unmapped access not refused");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata nonzero outside answer");
  a_go_pulse: assert property (prof_go |=> !prof_go)
    else $error("prof_go longer than one cycle");
  a_busy_on_go: assert property (prof_go |-> motion_busy)
    else $error("motion started without busy");
  a_busy_rise_go: assert property ($rose(motion_busy) |-> prof_go)
    else $error("busy rose without a start");
  // Starting is legal only from idle, stop is the exception
  a_start_idle: assert property ((prof_go && prof_cmd.mode != MTS_MODE_STOP)
    |-> !$past(motion_busy))
    else $error("new motion while busy");
  a_done_idle: assert property ((prof_done && motion_busy && prof_cmd.mode != MTS_MODE_VEL)
    |=> !motion_busy)
    else $error("busy kept after stop");

  c_home_run: cover property (prof_go && prof_cmd.mode == MTS_MODE_VEL);
  c_refused: cover property (pready && pslverr);
  c_done: cover property (prof_done && motion_busy);
endmodule

bind mts_sequencer mts_sequencer_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .first_event_input, .second_event_input,
  .enc_marker, .enc_step, .enc_dir, .prof_done, .prof_cmd, .prof_go, .motion_busy);

// >>> sim/mts_motor_model.sv
`timescale 1ns/1ps
// ****************************************
// Motor, profile generator and encoder
// ****************************************
module mts_motor_model
  import mts_pkg::*;
#(
  parameter int DECELERATION_RATE_STEPS = 3
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire mts_prof_cmd_t prof_cmd,
  input  wire logic          prof_go,
  output logic               enc_step,
  output logic               enc_dir,
  output logic               prof_done
);
  int         pos;
  int         left;
  logic       vel;
  logic       act;
  logic [2:0] tick;

  // One step per 8 cycles, slow enough for the synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos = 0; left = 0; vel = 0; act = 0; tick = 3'h0;
      enc_step <= 1'b0; enc_dir <= 1'b0; prof_done <= 1'b0;
    end else begin
      prof_done <= 1'b0;
      tick = tick + 3'h1;
      if (prof_go) begin
        act = 1'b1;
        tick = 3'h1;
        case (prof_cmd.mode)
          MTS_MODE_POS: begin
            left = int'(prof_cmd.target) - pos;
            enc_dir <= (left < 0);
            if (left < 0) left = -left;
          end
          MTS_MODE_VEL: begin
            vel = 1'b1;
            enc_dir <= prof_cmd.neg_dir;
          end
          MTS_MODE_STOP: begin
            vel = 1'b0; // Fixed coast of a few steps
            left = DECELERATION_RATE_STEPS;
          end
          default: ;
        endcase
      end else if (tick == 3'h0 && (vel || left > 0)) begin
        enc_step <= 1'b1;
        pos = pos + (enc_dir ? -1 : 1);
        if (!vel) left--;
      end else if (tick == 3'h4) begin
        enc_step <= 1'b0;
      end else if (act && !vel && left == 0 && tick == 3'h6) begin
        prof_done <= 1'b1;
        act = 1'b0;
      end
    end
  end
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ps
// ****************************************
// Sequencer testbench
// ****************************************
module tb;
  import mts_pkg::*;
  localparam int DECELERATION_RATE = 3;
  logic          pclk, presetn, psel, penable, pwrite, se;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic          pready, pslverr, ev1, ev2, marker;
  logic          enc_step, enc_dir, prof_done, prof_go, motion_busy;
  mts_prof_cmd_t prof_cmd, go_cmd;
  int            n_errors = 0, n_checks = 0, n_go = 0, i, k, g;
  logic [31:0]   tv[7] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h4, 32'h5, 32'h8000_0001};
  logic [31:0]   te[7] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h4, 32'h0, 32'h0};

  mts_sequencer DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .first_event_input(ev1), .second_event_input(ev2),
    .enc_marker(marker), .enc_step, .enc_dir, .prof_done, .prof_cmd, .prof_go, .motion_busy);
  mts_motor_model #(.DECELERATION_RATE_STEPS(DECELERATION_RATE)) u_motor (.pclk, .presetn, .prof_cmd, .prof_go,
    .enc_step, .enc_dir, .prof_done);

  // Clock and start monitor
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) if (prof_go === 1'b1) begin
    go_cmd <= prof_cmd;
    n_go <= n_go + 1;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Idle cycle first, so no signal is driven twice in one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    // Read at the edge; slave flops update later in the step, so pre-edge values
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    rd = prdata;
    se = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task automatic move(input mts_cmd_t c, input logic [31:0] v);
    xfer(1'b1, MTS_OFF_CMD_VAL, v);
    xfer(1'b1, MTS_OFF_CMD, {30'h0, c});
  endtask

  task automatic wait_idle;
    int j;
    for (j = 0; j < 100; j++) begin
      xfer(1'b0, MTS_OFF_STATUS, 32'h0);
      if (rd[1:0] === 2'b00) break;
    end
    if (j == 100) n_errors++;
  endtask

  task automatic tally_and_finish;
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    tally_and_finish;
  end

  // Main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; ev1 = 1'b0; ev2 = 1'b0; marker = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(MTS_OFF_TRIG_SEL, 32'h0, "trig_sel");
    rdchk(MTS_OFF_STATUS, 32'h0, "status");
    rdchk(MTS_OFF_SPEED, MTS_RST_SPEED, "speed");
    rdchk(MTS_OFF_HOME_SRC, 32'(MTS_RST_HOME_SRC), "home_src");
    for (i = 0; i < 7; i++) begin
      xfer(1'b1, MTS_OFF_TRIG_SEL, tv[i]);
      rdchk(MTS_OFF_TRIG_SEL, te[i], "trig_sel");
    end
    xfer(1'b1, 8'h24, 32'h5);
    chk("wr_slverr", 32'h1, 32'(se));
    rdchk(8'h24, 32'h0, "unmapped");
    chk("rd_slverr", 32'h1, 32'(se));
    xfer(1'b1, MTS_OFF_TRIG_SEL, 32'h2);
    xfer(1'b1, MTS_OFF_PROG, 32'h1);
    rdchk(MTS_OFF_TRIG_SEL, 32'h0, "trig_sel");
    // Signed incremental and absolute moves
    move(MTS_CMD_INC, 32'h5);
    wait_idle;
    chk("target", 32'h5, go_cmd.target);
    rdchk(MTS_OFF_ENC_POS, 32'h5, "enc_pos");
    move(MTS_CMD_INC, 32'hffff_fffd);
    wait_idle;
    rdchk(MTS_OFF_ABS_POS, 32'h2, "abs_pos");
    move(MTS_CMD_ABS, 32'hffff_fffc);
    wait_idle;
    rdchk(MTS_OFF_ABS_POS, 32'hffff_fffc, "abs_pos");
    // Out of range values start nothing
    g = n_go;
    move(MTS_CMD_INC, 32'h8000_0000);
    rdchk(MTS_OFF_STATUS, {MTS_ERR_RANGE, 8'h00}, "status");
    xfer(1'b1, MTS_OFF_STATUS, 32'h0);
    move(MTS_CMD_ABS, 32'h7fff_ffff);
    rdchk(MTS_OFF_STATUS, {MTS_ERR_RANGE, 8'h00}, "status");
    chk("starts", 32'(g), 32'(n_go));
    xfer(1'b1, MTS_OFF_STATUS, 32'h0);
    // Gated start on the first event, other input ignored
    xfer(1'b1, MTS_OFF_TRIG_SEL, 32'h1);
    move(MTS_CMD_INC, 32'h3);
    rdchk(MTS_OFF_STATUS, 32'h2, "status");
    xfer(1'b1, MTS_OFF_TRIG_SEL, 32'h2);
    rdchk(MTS_OFF_TRIG_SEL, 32'h1, "trig_sel");
    ev2 <= 1'b1;
    repeat (10) @(posedge pclk);
    ev2 <= 1'b0;
    rdchk(MTS_OFF_STATUS, 32'h2, "status");
    @(posedge pclk) ev1 <= 1'b1;
    k = 0;
    do begin
      @(negedge pclk);
      k++;
    end while (motion_busy !== 1'b1 && k < 20);
    chk("start_delay", 32'h1, 32'(k <= 4));
    @(posedge pclk) ev1 <= 1'b0;
    wait_idle;
    rdchk(MTS_OFF_ABS_POS, 32'hffff_ffff, "abs_pos");
    xfer(1'b1, MTS_OFF_TRIG_SEL, 32'h2);
    move(MTS_CMD_ABS, 32'h1);
    @(posedge pclk) ev2 <= 1'b1;
    wait_idle;
    ev2 <= 1'b0;
    rdchk(MTS_OFF_ABS_POS, 32'h1, "abs_pos");
    xfer(1'b1, MTS_OFF_TRIG_SEL, 32'h0);
    // Homing on the second event, negative direction
    xfer(1'b1, MTS_OFF_SPEED, 32'h7);
    xfer(1'b1, MTS_OFF_HOME_SRC, 32'(MTS_HSRC_EV2));
    move(MTS_CMD_HOME, 32'hffff_fff0);
    @(posedge enc_step);
    chk("home_cmd", {MTS_MODE_VEL, 1'b1}, {go_cmd.mode, go_cmd.neg_dir});
    chk("home_speed", 32'h7, go_cmd.speed);
    repeat (2) @(posedge pclk);
    ev2 <= 1'b1;
    wait_idle;
    chk("stop_cmd", 32'(MTS_MODE_STOP), 32'(go_cmd.mode));
    rdchk(MTS_OFF_ABS_POS, 32'(-DECELERATION_RATE), "abs_pos");
    rdchk(MTS_OFF_ENC_POS, 32'(-DECELERATION_RATE), "enc_pos");
    // Marker already active clears and does not move
    g = n_go;
    ev2 <= 1'b0;
    marker <= 1'b1;
    xfer(1'b1, MTS_OFF_HOME_SRC, 32'(MTS_HSRC_MARK));
    move(MTS_CMD_HOME, 32'h1);
    rdchk(MTS_OFF_ABS_POS, 32'h0, "abs_pos");
    rdchk(MTS_OFF_ENC_POS, 32'h0, "enc_pos");
    chk("starts", 32'(g), 32'(n_go));
    tally_and_finish;
  end
endmodule
